// file: logic/dpd_pkg.sv
// constants and types of the dual-port pixel output stage
//
// How it works
// - single-channel mode: every pixel goes to each channel's first port
// - single-channel mode: second ports are released to high impedance
// - dual-channel mode: consecutive pixels alternate between first and second ports
// - dual parallel form: both ports update together once per pixel pair
// - dual interleaved form: one port takes one new sample per incoming pixel
// - dual mode, swap bit clear: first pixel after line sync to first port, then alternate
// - dual mode, swap bit set: first pixel after line sync goes to second port
// - fixed pipeline depth from popped pixel to output ports, except the held first pixel of a dual parallel pair
// - phase field delays data, both strobe lines and line sync equally
// - output strobe is a complementary pair, synchronous to the core clock
// - single-channel mode: strobe runs at the pixel rate
// - dual-channel mode: strobe and data run at half the pixel rate
// - line sync output rebuilt from input sync, programmable polarity and width
// - every port of every colour channel is an 8-bit bus
`default_nettype none
package dpd_pkg;
  localparam int PIX_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int PHASE_W = 5;
  localparam int PHASE_TAPS = 32;
  localparam logic [7:0] ADDR_PHASE = 8'h04;
  localparam logic [7:0] ADDR_MODE = 8'h15;
  localparam logic [7:0] ADDR_HS_POL = 8'h30;
  localparam logic [7:0] ADDR_HS_WIDTH = 8'h31;
  localparam logic [7:0] ADDR_STATUS = 8'h32;
  localparam int PHASE_LSB = 3;
  localparam int PHASE_MSB = 7;
  localparam int MODE_LSB = 5;
  localparam int MODE_MSB = 7;
  localparam int MODE_DUAL = 2;
  localparam int MODE_PAR = 1;
  localparam int MODE_SWAP = 0;
  localparam logic [PHASE_W-1:0] PHASE_RST = 5'h00;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic HS_POL_RST = 1'b0;
  localparam logic [7:0] HS_WIDTH_RST = 8'h20;
  localparam logic [7:0] HS_WIDTH_MIN = 8'h01;

  typedef struct packed {
    logic [PIX_W-1:0] r;
    logic [PIX_W-1:0] g;
    logic [PIX_W-1:0] b;
  } dpd_pix_t;

  typedef struct packed {
    logic line;
    dpd_pix_t pix;
  } dpd_word_t;

  typedef struct packed {
    dpd_pix_t a;
    dpd_pix_t b;
    logic b_oe_n;
    logic strobe;
    logic strobe_n;
    logic hs;
  } dpd_out_t;

  localparam dpd_out_t OUT_RST = '{a: '0, b: '0, b_oe_n: 1'b1, strobe: 1'b0,
                                   strobe_n: 1'b1, hs: 1'b0};
endpackage
`default_nettype wire

// file: logic/dpd_fifo.sv
// small synchronous fifo with valid/ready on both sides
`default_nettype none
module dpd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic rdy_q, rdy_d;
  logic push, pop;

  always_comb
  begin
    push = in_valid && rdy_q;
    pop = out_valid && out_ready;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push)
      wp_d = (wp_q == LAST) ? '0 : AW'(wp_q + 1'b1);
    if (pop)
      rp_d = (rp_q == LAST) ? '0 : AW'(rp_q + 1'b1);
    if (push && !pop)
      cnt_d = CW'(cnt_q + 1'b1);
    else if (pop && !push)
      cnt_d = CW'(cnt_q - 1'b1);
    // registered ready from the next count: a full fifo refuses from its first full cycle on
    rdy_d = cnt_d != FULL;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b1;
    end
    else
    begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wp_q] <= in_data;
  end

  assign in_ready = rdy_q;
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rp_q];
  assign level = cnt_q;

  a_fifo_no_overrun: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_q == FULL |-> !rdy_q)
    else $error("fifo ready while full");
endmodule
`default_nettype wire

// file: logic/dpd_demux.sv
// pixel port demultiplexer with phase-aligned strobe pair and line sync
`default_nettype none
module dpd_demux (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic PIX_VALID,
  output logic PIX_READY,
  input wire dpd_pkg::dpd_pix_t PIX_IN,
  input wire logic PIX_LINE_START,
  output logic [dpd_pkg::PIX_W-1:0] RED_FIRST_PORT_BUS,
  output logic [dpd_pkg::PIX_W-1:0] RED_SECOND_PORT_BUS,
  output logic [dpd_pkg::PIX_W-1:0] GREEN_FIRST_PORT_BUS,
  output logic [dpd_pkg::PIX_W-1:0] GREEN_SECOND_PORT_BUS,
  output logic [dpd_pkg::PIX_W-1:0] BLUE_FIRST_PORT_BUS,
  output logic [dpd_pkg::PIX_W-1:0] BLUE_SECOND_PORT_BUS,
  output logic SECOND_PORT_OE_N,
  output logic OUTPUT_PIXEL_STROBE,
  output logic OUTPUT_PIXEL_STROBE_N,
  output logic RECOVERED_LINE_SYNC_OUT
);
  localparam int WW = $bits(dpd_pkg::dpd_word_t);
  localparam int LW = $clog2(dpd_pkg::FIFO_DEPTH + 1);

  // register group
  logic [dpd_pkg::PHASE_W-1:0] phase_q, phase_d;
  logic [2:0] mode_q, mode_d;
  logic pol_q, pol_d;
  logic [7:0] width_q, width_d;
  logic [7:0] rdata_q, rdata_d;

  // datapath group
  logic tick_q, tick_d;
  logic pos_q, pos_d;
  dpd_pkg::dpd_pix_t hold_q, hold_d;
  logic [7:0] hs_cnt_q, hs_cnt_d;
  dpd_pkg::dpd_out_t st_q, st_d;

  // phase delay group
  dpd_pkg::dpd_out_t taps_q [dpd_pkg::PHASE_TAPS-1];
  dpd_pkg::dpd_out_t taps_d [dpd_pkg::PHASE_TAPS-1];
  dpd_pkg::dpd_out_t out_q, out_d;

  dpd_pkg::dpd_word_t in_word, f_word;
  logic f_valid, f_ready, pop;
  logic [LW-1:0] f_level;
  logic dual, par, swap, pos_cur, tgt_b;

  assign in_word = '{line: PIX_LINE_START, pix: PIX_IN};

  dpd_fifo #(
    .WIDTH(WW),
    .DEPTH(dpd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(CORE_CLK),
    .rst_n(RST_B),
    .in_valid(PIX_VALID),
    .in_ready(PIX_READY),
    .in_data(in_word),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_word),
    .level(f_level)
  );

  always_comb
  begin
    phase_d = phase_q;
    mode_d = mode_q;
    pol_d = pol_q;
    width_d = width_q;
    rdata_d = 8'h00;
    if (REG_WR)
    begin
      case (REG_ADDR)
        dpd_pkg::ADDR_PHASE: phase_d = REG_WDATA[dpd_pkg::PHASE_MSB:dpd_pkg::PHASE_LSB];
        dpd_pkg::ADDR_MODE: mode_d = REG_WDATA[dpd_pkg::MODE_MSB:dpd_pkg::MODE_LSB];
        dpd_pkg::ADDR_HS_POL: pol_d = REG_WDATA[0];
        dpd_pkg::ADDR_HS_WIDTH: width_d = REG_WDATA;
        default: ;
      endcase
    end
    if (REG_RD)
    begin
      // unused bits and unmapped addresses read as zero
      case (REG_ADDR)
        dpd_pkg::ADDR_PHASE: rdata_d = {phase_q, 3'h0};
        dpd_pkg::ADDR_MODE: rdata_d = {mode_q, 5'h00};
        dpd_pkg::ADDR_HS_POL: rdata_d = {7'h00, pol_q};
        dpd_pkg::ADDR_HS_WIDTH: rdata_d = width_q;
        dpd_pkg::ADDR_STATUS: rdata_d = 8'({f_level, pos_q});
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      phase_q <= dpd_pkg::PHASE_RST;
      mode_q <= dpd_pkg::MODE_RST;
      pol_q <= dpd_pkg::HS_POL_RST;
      width_q <= dpd_pkg::HS_WIDTH_RST;
      rdata_q <= 8'h00;
    end
    else
    begin
      phase_q <= phase_d;
      mode_q <= mode_d;
      pol_q <= pol_d;
      width_q <= width_d;
      rdata_q <= rdata_d;
    end
  end

  assign dual = mode_q[dpd_pkg::MODE_DUAL];
  assign par = mode_q[dpd_pkg::MODE_PAR];
  assign swap = mode_q[dpd_pkg::MODE_SWAP];
  // one pixel slot every second core cycle, so the strobe can toggle at pixel rate
  assign f_ready = tick_q;
  assign pop = tick_q && f_valid;
  assign pos_cur = f_word.line ? 1'b0 : pos_q;
  assign tgt_b = pos_cur ^ swap;

  always_comb
  begin
    tick_d = ~tick_q;
    pos_d = pos_q;
    hold_d = hold_q;
    st_d = st_q;
    hs_cnt_d = (hs_cnt_q != 8'h00) ? 8'(hs_cnt_q - 8'h01) : 8'h00;
    st_d.b_oe_n = ~dual;
    if (pop)
    begin
      if (f_word.line)
        hs_cnt_d = (width_q < dpd_pkg::HS_WIDTH_MIN) ? dpd_pkg::HS_WIDTH_MIN : width_q;
      if (!dual)
        st_d.a = f_word.pix;
      else
      begin
        pos_d = ~pos_cur;
        st_d.strobe = pos_cur;
        if (!par)
        begin
          if (tgt_b)
            st_d.b = f_word.pix;
          else
            st_d.a = f_word.pix;
        end
        else if (!pos_cur)
          hold_d = f_word.pix;
        else if (tgt_b)
        begin
          st_d.b = f_word.pix;
          st_d.a = hold_q;
        end
        else
        begin
          st_d.a = f_word.pix;
          st_d.b = hold_q;
        end
      end
    end
    if (!dual)
      st_d.strobe = pop;
    st_d.strobe_n = ~st_d.strobe;
    st_d.hs = (hs_cnt_d != 8'h00) ^ pol_q;
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      tick_q <= 1'b0;
      pos_q <= 1'b0;
      hold_q <= '0;
      hs_cnt_q <= 8'h00;
      st_q <= dpd_pkg::OUT_RST;
    end
    else
    begin
      tick_q <= tick_d;
      pos_q <= pos_d;
      hold_q <= hold_d;
      hs_cnt_q <= hs_cnt_d;
      st_q <= st_d;
    end
  end

  // the whole output bundle rides one delay line, so moving the phase
  // cannot skew data against strobe or sync
  assign taps_d[0] = st_q;
  generate
    for (genvar i = 1; i < dpd_pkg::PHASE_TAPS - 1; i++)
    begin : g_tap
      assign taps_d[i] = taps_q[i-1];
    end
  endgenerate

  always_comb
  begin
    if (phase_q == dpd_pkg::PHASE_RST)
      out_d = st_q;
    else
      out_d = taps_q[5'(phase_q - 5'h01)];
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      for (int i = 0; i < dpd_pkg::PHASE_TAPS - 1; i++)
        taps_q[i] <= dpd_pkg::OUT_RST;
      out_q <= dpd_pkg::OUT_RST;
    end
    else
    begin
      taps_q <= taps_d;
      out_q <= out_d;
    end
  end

  assign REG_RDATA = rdata_q;
  assign RED_FIRST_PORT_BUS = out_q.a.r;
  assign GREEN_FIRST_PORT_BUS = out_q.a.g;
  assign BLUE_FIRST_PORT_BUS = out_q.a.b;
  assign RED_SECOND_PORT_BUS = out_q.b.r;
  assign GREEN_SECOND_PORT_BUS = out_q.b.g;
  assign BLUE_SECOND_PORT_BUS = out_q.b.b;
  assign SECOND_PORT_OE_N = out_q.b_oe_n;
  assign OUTPUT_PIXEL_STROBE = out_q.strobe;
  assign OUTPUT_PIXEL_STROBE_N = out_q.strobe_n;
  assign RECOVERED_LINE_SYNC_OUT = out_q.hs;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);

  a_single_port_a: assert property (
    pop && !dual |=> st_q.a == $past(f_word.pix))
    else $error("single mode pixel not on first port");
  a_single_b_off: assert property (
    !dual |=> st_q.b_oe_n)
    else $error("second port driven in single mode");
  a_line_first_port: assert property (
    pop && dual && !par && !swap && f_word.line |=> st_q.a == $past(f_word.pix))
    else $error("first pixel after line sync not on first port");
  a_swap_first_port: assert property (
    pop && dual && !par && swap && f_word.line |=> st_q.b == $past(f_word.pix))
    else $error("swapped first pixel not on second port");
  a_par_first_holds: assert property (
    pop && dual && par && !pos_cur |=> $stable(st_q.a) && $stable(st_q.b))
    else $error("parallel ports moved on first pixel of pair");
  a_dual_alternate: assert property (
    pop && dual ##1 pos_q == 1'b1 ##1 pop && dual && !f_word.line |=> pos_q == 1'b0)
    else $error("dual mode did not alternate ports");
  a_single_rate: assert property (
    pop && !dual |=> st_q.strobe ##1 !st_q.strobe)
    else $error("single mode strobe not one cycle per pixel");
  a_dual_half_rate: assert property (
    pop && dual |=> st_q.strobe == ($past(f_word.line) ? 1'b0 : !$past(st_q.strobe)))
    else $error("dual mode strobe did not toggle per pixel");
  a_strobe_pair: assert property (
    out_q.strobe_n == ~out_q.strobe)
    else $error("strobe pair not complementary");
  a_phase_zero_align: assert property (
    $past(phase_q) == 5'h00 |-> out_q == $past(st_q))
    else $error("output bundle not aligned at phase zero");
  a_sync_start: assert property (
    pop && f_word.line |=> st_q.hs == ~pol_q [*1])
    else $error("line sync pulse did not start");

  c_single_pixel: cover property (pop && !dual);
  c_dual_pair: cover property (pop && dual && par && pos_cur);
  c_swap_line: cover property (pop && dual && swap && f_word.line);
  c_fifo_full: cover property (!PIX_READY);
endmodule
`default_nettype wire

// file: logic/dpd_fifo_unused_placeholder_none.sv
// intentionally empty compile unit
`default_nettype none
`default_nettype wire

// file: tb/dpd_rx_model.sv
// receiver model that strobes the red ports and line sync on each rising output strobe
`default_nettype none
module dpd_rx_model (
  input wire logic clk,
  input wire logic strobe,
  input wire logic [7:0] a_red,
  input wire logic [7:0] b_red,
  input wire logic sync,
  output logic [7:0] cap_a,
  output logic [7:0] cap_b,
  output logic cap_sync
);
  timeunit 1ns;
  timeprecision 1ns;
  logic strobe_q;
  // sampled on the core clock: strobe and data leave the same edge, a strobe edge would race
  always @(posedge clk)
  begin
    strobe_q <= strobe;
    if (strobe && !strobe_q)
    begin
      cap_a <= a_red;
      cap_b <= b_red;
      cap_sync <= sync;
    end
  end
endmodule
`default_nettype wire

// file: tb/dpd_demux_tb_top.sv
// self-checking bench of the dual-port pixel output stage
`default_nettype none
module dpd_demux_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic pix_valid = 1'b0, line = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata, ra, rb, ga, gb, ba, bb;
  logic [7:0] cap_a, cap_b, d;
  dpd_pkg::dpd_pix_t pix = '0;
  logic ready, oe_n, stb, stb_n, hs, cap_hs;
  int num_errors = 0, n_checks = 0, cyc = 0;
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  dpd_demux uut (.CORE_CLK(core_clk), .RST_B(rst_b), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata),
    .PIX_VALID(pix_valid), .PIX_READY(ready), .PIX_IN(pix), .PIX_LINE_START(line),
    .RED_FIRST_PORT_BUS(ra), .RED_SECOND_PORT_BUS(rb), .GREEN_FIRST_PORT_BUS(ga),
    .GREEN_SECOND_PORT_BUS(gb), .BLUE_FIRST_PORT_BUS(ba), .BLUE_SECOND_PORT_BUS(bb),
    .SECOND_PORT_OE_N(oe_n), .OUTPUT_PIXEL_STROBE(stb), .OUTPUT_PIXEL_STROBE_N(stb_n),
    .RECOVERED_LINE_SYNC_OUT(hs));
  dpd_rx_model rx (.clk(core_clk), .strobe(stb), .a_red(ra), .b_red(rb), .sync(hs),
    .cap_a(cap_a), .cap_b(cap_b), .cap_sync(cap_hs));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask

  // holds the pixel until the fifo takes it
  task automatic push(input logic [23:0] p, input logic l);
    @(posedge core_clk);
    pix_valid <= 1'b1;
    pix <= p;
    line <= l;
    do @(negedge core_clk); while (ready !== 1'b1);
    @(posedge core_clk);
    pix_valid <= 1'b0;
  endtask

  // bounded wait for the strobe, or for one port to show a value
  task automatic wv(input int what, input logic [7:0] v, output int n);
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while (n < 80 && (what == 0 ? stb : (what == 1 ? ra : rb)) !== (what == 0 ? 1 : v));
  endtask

  task automatic t_regs;
    rd(8'h04);
    chk("phase rst", d, 8'h00);
    rd(8'h15);
    chk("mode rst", d, 8'h00);
    rd(8'h7F);
    chk("unmapped", d, 8'h00);
    chk("b hiz rst", oe_n, 1'b1);
    wr(8'h15, 8'hE0);
    rd(8'h15);
    chk("mode rw", d, 8'hE0);
    wr(8'h15, 8'h00);
  endtask

  task automatic t_single;
    int n;
    push(24'hA1B2C3, 1'b1);
    wv(0, 8'h00, n);
    chk("ra", ra, 8'hA1);
    chk("ga", ga, 8'hB2);
    chk("ba", ba, 8'hC3);
    chk("b hiz", oe_n, 1'b1);
    chk("stb pair", stb_n, !stb);
    chk("sync", hs, 1'b1);
    @(negedge core_clk);
    chk("stb fall", stb, 1'b0);
    chk("rx cap", cap_a, 8'hA1);
  endtask

  // each start lies a fixed even span later, so the drain slot parity stays the same
  task automatic t_phase;
    int t0, n, lat[3];
    // start on a rising edge so every push lies an even number of cycles after t0
    @(posedge core_clk);
    t0 = cyc;
    for (int i = 0; i < 3; i++)
    begin
      if (i == 2)
        wr(8'h04, 8'h28);
      while (cyc < t0 + 60 * i)
        @(posedge core_clk);
      push(24'h5A5A5A, 1'b1);
      wv(0, 8'h00, n);
      lat[i] = cyc - t0 - 60 * i;
      chk("sync align", hs, 1'b1);
    end
    chk("lat fixed", lat[1], lat[0]);
    chk("lat phase", lat[2], lat[0] + 5);
    wr(8'h04, 8'h00);
  endtask

  task automatic t_dual(input int i);
    int n;
    logic [7:0] v;
    v = 8'h40 + 8'(i * 16);
    wr(8'h15, {1'b1, i[0], i[1], 5'h00});
    push({3{v}}, 1'b1);
    push({3{v + 8'h01}}, 1'b0);
    wv(i[1] ? 2 : 1, v, n);
    chk("first port", n < 80, 1'b1);
    chk("b driven", oe_n, 1'b0);
    chk("pair", (i[1] ? ra : rb) === v + 8'h01, i[0]);
    wv(i[1] ? 1 : 2, v + 8'h01, n);
    chk("second port", n < 80, 1'b1);
    chk("stb half", stb, 1'b1);
    chk("gb", gb, i[1] ? v : v + 8'h01);
    chk("bb", bb, i[1] ? v : v + 8'h01);
    @(negedge core_clk);
    chk("rx cap b", cap_b, i[1] ? v : v + 8'h01);
    chk("rx cap sync", cap_hs, 1'b1);
  endtask

  // inverted polarity and a two-cycle pulse
  task automatic t_sync;
    int n;
    wr(8'h30, 8'h01);
    wr(8'h31, 8'h02);
    rd(8'h30);
    chk("pol rw", d, 8'h01);
    rd(8'h31);
    chk("width rw", d, 8'h02);
    chk("sync idle", hs, 1'b1);
    push(24'h3C3C3C, 1'b1);
    wv(0, 8'h00, n);
    chk("sync low", hs, 1'b0);
    @(negedge core_clk);
    chk("sync held", hs, 1'b0);
    chk("rx cap sync low", cap_hs, 1'b0);
    @(negedge core_clk);
    chk("sync width", hs, 1'b1);
  endtask

  task automatic t_fill;
    logic saw;
    saw = 1'b0;
    wr(8'h15, 8'h00);
    @(posedge core_clk);
    pix_valid <= 1'b1;
    line <= 1'b0;
    repeat (12)
    begin
      @(negedge core_clk);
      if (ready === 1'b0)
        saw = 1'b1;
    end
    @(posedge core_clk);
    pix_valid <= 1'b0;
    chk("fifo full", saw, 1'b1);
    repeat (60) @(posedge core_clk);
    rd(8'h32);
    chk("fifo empty", d & 8'h0E, 8'h00);
    chk("ready", ready, 1'b1);
  endtask

  initial
  begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    t_regs;
    t_single;
    t_phase;
    for (int i = 0; i < 4; i++)
      t_dual(i);
    t_fill;
    t_sync;
    summarize();
  end

  // the whole run needs well under two thousand cycles
  initial
  begin
    #2000000;
    num_errors++;
    summarize();
  end
endmodule
`default_nettype wire
